// ===== hdl/apoe_top.v
/*
 * Operator data entry decoder for the auxiliary serial port, with an
 * APB register slave. Holds the last character, the terminated
 * string and number, the status code and the communication
 * interrupt divert. Assumes the receive UART, the program state
 * inputs and APB all run on pclk, so none is resynchronised.
 */
// Implementation choices: the APB register port and the register offsets.
// Notes on behaviour
// - Entry exists only on auxiliary port two.
// - Entry works only while a program runs.
// - Backslash or escape leaves entry mode.
// - Last received character is always readable.
// - Terminated string is kept readable.
// - Terminated number is kept readable.
// - Status: -1 off, 0,1,2,3 as received.
// - Reading string or number clears status; only the upper word read clears it.
// - Selector: none, on enter, on any.
// - Writing -1 to selector flushes buffer.
// - Qualifying character diverts to the handler.
// - Handler return rearms only with argument one.
// - Interrupt armed only while thread zero runs.
// - Six-byte holder: integer then fraction.
// - String takes requested count, six by default.
// - First character lands in top byte.
`timescale 1ns/1ps
`default_nettype none
`include "apoe_defs.vh"

module apoe_top #(
  parameter NUM_W = 32,
  parameter FRC_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire aux_rx_valid,
  input wire [7:0] aux_rx_char,
  input wire program_running,
  input wire thread0_running,
  output reg com_divert,
  output reg entry_active
);

  // -----------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------
  reg entry_en_ff; // Entry mode enable, the third config field.
  reg [2:0] len_spec_ff; // String length specifier, 0 means six.
  reg [1:0] cisel_ff; // Communication interrupt selector.
  reg [7:0] last_rx_char_ff; // Most recent character.
  reg [47:0] buf_ff; // Characters of the entry in progress.
  reg [2:0] cnt_ff; // Characters held in buf_ff.
  reg [47:0] rx_string_holder_ff; // Last terminated string.
  reg [47:0] rx_number_holder_ff; // Last terminated number.
  reg [1:0] code_ff; // Status code while entry mode is on.
  reg armed_ff; // Interrupt armed.
  reg busy_ff; // Handler running, program diverted.

  reg nxt_entry_en;
  reg [1:0] nxt_cisel;
  reg [47:0] nxt_buf;
  reg [2:0] nxt_cnt;
  reg [47:0] nxt_str;
  reg [47:0] nxt_num;
  reg [1:0] nxt_code;
  reg nxt_armed;
  reg nxt_busy;
  reg acc_clr; // Restart the decimal accumulator.
  reg [31:0] rd_mux; // Read data for the addressed register.
  reg rd_hit; // Address is mapped.

  wire setup;
  wire wr_acc;
  wire rd_acc;
  wire active;
  wire is_exit;
  wire is_enter;
  wire [2:0] limit;
  wire [5:0] slot;
  wire [NUM_W-1:0] acc_val;
  wire acc_num;
  wire acc_feed;
  wire qualify;
  wire [31:0] stat_rd;

  // -----------------------------------------------------------------
  // APB decode.
  // -----------------------------------------------------------------
  // The slave answers in the first access cycle, so no wait states.
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;

  // -----------------------------------------------------------------
  // Receive qualification.
  // -----------------------------------------------------------------
  // Only the auxiliary receiver feeds this block; the main port has
  // no path here at all.
  assign active = entry_en_ff && program_running;
  assign is_exit = (aux_rx_char == `APOE_CH_BSLASH) ||
                   (aux_rx_char == `APOE_CH_ESC);
  assign is_enter = aux_rx_char == `APOE_CH_ENTER;
  // A count of zero or above six falls back to six.
  assign limit = (len_spec_ff == 3'h0 || len_spec_ff > `APOE_LEN_MAX)
                 ? `APOE_LEN_MAX : len_spec_ff;
  // Byte slot counts down from the top byte.
  assign slot = 6'h28 - {cnt_ff, 3'h0};
  // Terminators never reach the accumulator, so a lone sign or an
  // empty entry has no digit and is reported as a string.
  assign acc_feed = aux_rx_valid && active && !is_exit && !is_enter;
  assign qualify = aux_rx_valid && active &&
                   ((cisel_ff == `APOE_CI_ANY) ||
                    (cisel_ff == `APOE_CI_ENTER && is_enter));
  assign stat_rd = entry_en_ff ? {30'h0, code_ff}
                               : `APOE_ST_OFF;

  apoe_dec_acc #(
    .WIDTH(NUM_W)
  ) u_acc (
    .pclk(pclk),
    .presetn(presetn),
    .clr(acc_clr),
    .ch_valid(acc_feed),
    .ch(aux_rx_char),
    .value(acc_val),
    .is_num(acc_num)
  );

  // -----------------------------------------------------------------
  // Next-state logic for entry, holders and interrupt.
  // -----------------------------------------------------------------
  // Order matters: software clears come first so that a hardware
  // event in the same cycle overrides them.
  always @* begin
    nxt_entry_en = entry_en_ff;
    nxt_cisel = cisel_ff;
    nxt_buf = buf_ff;
    nxt_cnt = cnt_ff;
    nxt_str = rx_string_holder_ff;
    nxt_num = rx_number_holder_ff;
    nxt_code = code_ff;
    nxt_armed = armed_ff;
    nxt_busy = busy_ff;
    acc_clr = 1'b0;
    // Software side: configuration, selector and handler return writes.
    if (wr_acc) begin
      case (paddr)
        `APOE_OFS_CFG: begin
          nxt_entry_en = pwdata[`APOE_CFG_EN_BIT];
        end
        `APOE_OFS_CISEL: begin
          if (pwdata == `APOE_CI_FLUSH) begin
            nxt_buf = 48'h0;
            nxt_cnt = 3'h0;
            acc_clr = 1'b1;
          end else if (pwdata[31:2] == 30'h0 &&
                       pwdata[1:0] != 2'h3) begin
            nxt_cisel = pwdata[1:0];
            // Selecting a trigger arms; selecting none disarms.
            nxt_armed = (pwdata[1:0] != `APOE_CI_NONE);
          end
        end
        `APOE_OFS_HDL: begin
          if (busy_ff) begin
            nxt_busy = 1'b0;
            nxt_armed = pwdata[`APOE_HDL_REARM_BIT];
          end
        end
        // Writes to read-only holders are ignored without an error.
        default: begin
        end
      endcase
    end
    // Reading the upper word of the matching holder returns the code to idle.
    if (rd_acc) begin
      if ((paddr == `APOE_OFS_STRHI && code_ff == `APOE_ST_STRING) ||
          (paddr == `APOE_OFS_NUMINT && code_ff == `APOE_ST_NUMBER))
        nxt_code = `APOE_ST_IDLE;
    end
    // Hardware side: received characters.
    if (aux_rx_valid && active) begin
      if (is_exit) begin
        nxt_entry_en = 1'b0;
        nxt_buf = 48'h0;
        nxt_cnt = 3'h0;
        acc_clr = 1'b1;
      end else if (is_enter) begin
        if (acc_num) begin
          // Integer part high, fraction low and zero.
          nxt_num = {acc_val, {FRC_W{1'b0}}};
          nxt_code = `APOE_ST_NUMBER;
        end else begin
          nxt_str = buf_ff;
          nxt_code = `APOE_ST_STRING;
        end
        nxt_buf = 48'h0;
        nxt_cnt = 3'h0;
        acc_clr = 1'b1;
      end else begin
        // Extra characters beyond the limit are dropped from the
        // string but still count towards the number.
        if (cnt_ff < limit) begin
          nxt_buf[slot +: 8] = aux_rx_char;
          nxt_cnt = cnt_ff + 3'h1;
        end
        nxt_code = `APOE_ST_CHARS;
      end
    end
    // Divert: the handler owns the program until it returns. The
    // next-state arm and busy values are used so that a character
    // that arrives with a selector write or a handler return in the
    // same cycle is not lost: the hardware event wins over the
    // software update.
    if (qualify && nxt_armed && thread0_running && !nxt_busy) begin
      nxt_busy = 1'b1;
      nxt_armed = 1'b0;
    end
    // The interrupt may only stay armed while thread zero runs.
    if (!thread0_running)
      nxt_armed = 1'b0;
  end

  // -----------------------------------------------------------------
  // State registers.
  // -----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_en_ff <= 1'b0;
      cisel_ff <= `APOE_CISEL_RST;
      buf_ff <= 48'h0;
      cnt_ff <= 3'h0;
      rx_string_holder_ff <= 48'h0;
      rx_number_holder_ff <= 48'h0;
      code_ff <= `APOE_ST_IDLE;
      armed_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      entry_en_ff <= nxt_entry_en;
      cisel_ff <= nxt_cisel;
      buf_ff <= nxt_buf;
      cnt_ff <= nxt_cnt;
      rx_string_holder_ff <= nxt_str;
      rx_number_holder_ff <= nxt_num;
      code_ff <= nxt_code;
      armed_ff <= nxt_armed;
      busy_ff <= nxt_busy;
    end
  end

  // -----------------------------------------------------------------
  // Length specifier and last character.
  // -----------------------------------------------------------------
  // The last character updates on every receive, in or out of mode.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_spec_ff <= 3'h0;
      last_rx_char_ff <= 8'h0;
    end else begin
      if (wr_acc && paddr == `APOE_OFS_CFG)
        len_spec_ff <= pwdata[`APOE_CFG_LEN_MSB:`APOE_CFG_LEN_LSB];
      if (aux_rx_valid)
        last_rx_char_ff <= aux_rx_char;
    end
  end

  // -----------------------------------------------------------------
  // Read multiplexer.
  // -----------------------------------------------------------------
  // Unaligned or unknown offsets fall to the default branch and the
  // transfer answers with an error and zero data.
  always @* begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (paddr)
      `APOE_OFS_CFG: begin
        rd_mux = {25'h0, len_spec_ff, 3'h0, entry_en_ff};
      end
      `APOE_OFS_CISEL: begin
        rd_mux = {30'h0, cisel_ff};
      end
      `APOE_OFS_LAST: begin
        rd_mux = {24'h0, last_rx_char_ff};
      end
      `APOE_OFS_STAT: begin
        rd_mux = stat_rd;
      end
      `APOE_OFS_STRHI: begin
        rd_mux = rx_string_holder_ff[47:16];
      end
      `APOE_OFS_STRLO: begin
        rd_mux = {16'h0, rx_string_holder_ff[15:0]};
      end
      `APOE_OFS_NUMINT: begin
        rd_mux = rx_number_holder_ff[47:16];
      end
      `APOE_OFS_NUMFRC: begin
        rd_mux = {16'h0, rx_number_holder_ff[15:0]};
      end
      `APOE_OFS_HDL: begin
        rd_mux = {30'h0, busy_ff, armed_ff};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // APB answer and output flops.
  // -----------------------------------------------------------------
  // Read data is captured in setup, so a status read sees the value
  // before any clear that the same read causes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      com_divert <= 1'b0;
      entry_active <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
        pslverr <= !rd_hit;
      end else begin
        pslverr <= 1'b0;
      end
      com_divert <= nxt_busy;
      entry_active <= nxt_entry_en && program_running;
    end
  end

endmodule
`default_nettype wire

// ===== include/apoe_defs.vh
/*
 * Constants for the auxiliary port operator entry block: register
 * offsets, field positions, status codes and special characters.
 * Assumes it is included by bare name from the design files.
 */
`ifndef APOE_DEFS_VH
`define APOE_DEFS_VH

// ------------------------------------------------------------------
// Register byte offsets.
// ------------------------------------------------------------------
`define APOE_OFS_CFG 8'h00
`define APOE_OFS_CISEL 8'h04
`define APOE_OFS_LAST 8'h08
`define APOE_OFS_STAT 8'h0c
`define APOE_OFS_STRHI 8'h10
`define APOE_OFS_STRLO 8'h14
`define APOE_OFS_NUMINT 8'h18
`define APOE_OFS_NUMFRC 8'h1c
`define APOE_OFS_HDL 8'h20

// ------------------------------------------------------------------
// Field positions and reset values.
// ------------------------------------------------------------------
`define APOE_CFG_EN_BIT 0
`define APOE_CFG_LEN_LSB 4
`define APOE_CFG_LEN_MSB 6
`define APOE_HDL_REARM_BIT 0
`define APOE_HDL_BUSY_BIT 1
`define APOE_HDL_ARMED_BIT 0
`define APOE_LEN_MAX 3'h6
`define APOE_CISEL_RST 2'h0

// ------------------------------------------------------------------
// Interrupt selector values and status codes.
// ------------------------------------------------------------------
`define APOE_CI_NONE 2'h0
`define APOE_CI_ENTER 2'h1
`define APOE_CI_ANY 2'h2
`define APOE_CI_FLUSH 32'hffffffff
`define APOE_ST_IDLE 2'h0
`define APOE_ST_CHARS 2'h1
`define APOE_ST_STRING 2'h2
`define APOE_ST_NUMBER 2'h3
`define APOE_ST_OFF 32'hffffffff

// ------------------------------------------------------------------
// Special characters.
// ------------------------------------------------------------------
`define APOE_CH_ENTER 8'h0d
`define APOE_CH_ESC 8'h1b
`define APOE_CH_BSLASH 8'h5c
`define APOE_CH_MINUS 8'h2d
`define APOE_CH_PLUS 8'h2b
`define APOE_CH_ZERO 8'h30
`define APOE_CH_NINE 8'h39

`endif

// ===== hdl/apoe_dec_acc.v
/*
 * Signed decimal accumulator. Takes one character at a time and
 * keeps the running value and whether all input so far is a number.
 * Assumes characters arrive on the same clock as pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "apoe_defs.vh"

module apoe_dec_acc #(
  parameter WIDTH = 32
) (
  input wire pclk,
  input wire presetn,
  input wire clr,
  input wire ch_valid,
  input wire [7:0] ch,
  output wire [WIDTH-1:0] value,
  output wire is_num
);

  reg [WIDTH-1:0] mag_ff; // Magnitude so far.
  reg neg_ff; // A leading minus was seen.
  reg any_ff; // At least one character was seen.
  reg digit_ff; // At least one digit was seen.
  reg bad_ff; // Some character broke the number form.

  wire is_digit;
  wire is_sign;
  wire [WIDTH-1:0] dval;
  wire [WIDTH+3:0] prod;

  assign is_digit = (ch >= `APOE_CH_ZERO) && (ch <= `APOE_CH_NINE);
  assign is_sign = (ch == `APOE_CH_MINUS) || (ch == `APOE_CH_PLUS);
  assign dval = {{(WIDTH-8){1'b0}}, ch - `APOE_CH_ZERO};
  // Overflow wraps silently; entries are short in practice.
  assign prod = {4'h0, mag_ff} * 4'ha;

  // -----------------------------------------------------------------
  // Accumulation.
  // -----------------------------------------------------------------
  // A sign counts only as the very first character.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mag_ff <= {WIDTH{1'b0}};
      neg_ff <= 1'b0;
      any_ff <= 1'b0;
      digit_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else if (clr) begin
      mag_ff <= {WIDTH{1'b0}};
      neg_ff <= 1'b0;
      any_ff <= 1'b0;
      digit_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else if (ch_valid) begin
      any_ff <= 1'b1;
      if (is_digit) begin
        mag_ff <= prod[WIDTH-1:0] + dval;
        digit_ff <= 1'b1;
      end else if (is_sign && !any_ff) begin
        neg_ff <= (ch == `APOE_CH_MINUS);
      end else begin
        bad_ff <= 1'b1;
      end
    end
  end

  // The value is signed two's complement.
  assign value = neg_ff ? (~mag_ff + {{(WIDTH-1){1'b0}}, 1'b1}) : mag_ff;
  assign is_num = digit_ff && !bad_ff;

endmodule
`default_nettype wire

// ===== sim/apoe_checker.sv
/*
 * Port checker for the operator entry block.
 * Assumes it is bound to apoe_top and that everything runs on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module apoe_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic aux_rx_valid,
  input wire logic [7:0] aux_rx_char,
  input wire logic program_running,
  input wire logic thread0_running,
  input wire logic com_divert,
  input wire logic entry_active
);
  // ----------------------------------------------------------------
  // Assertions, all on pclk.
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The slave never inserts wait states.
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  property p_unmap; psel && penable && paddr > 8'h20 |-> pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped ok");
  property p_run; entry_active |-> $past(program_running); endproperty
  a_run: assert property (p_run) else $error("entry w/o program");
  // Exit may take effect through the enable register first.
  property p_exit; aux_rx_valid && (aux_rx_char == 8'h1b ||
    aux_rx_char == 8'h5c) |-> ##[1:2] !entry_active; endproperty
  a_exit: assert property (p_exit) else $error("no exit");
  property p_stat; psel && penable && !pwrite && paddr == 8'h0c &&
    entry_active |-> prdata[31:2] == 30'h0; endproperty
  a_stat: assert property (p_stat) else $error("status range");
  property p_fire; $rose(com_divert) |-> ($past(aux_rx_valid) &&
    $past(thread0_running)) || ($past(aux_rx_valid, 2) &&
    $past(thread0_running, 2)); endproperty
  a_fire: assert property (p_fire) else $error("bad divert");
  property p_hold; com_divert && !(psel && penable && pwrite &&
    paddr == 8'h20) |=> com_divert; endproperty
  a_hold: assert property (p_hold) else $error("divert lost");
endmodule
`default_nettype wire

// ===== sim/apoe_term.sv
/*
 * Operator terminal model on the auxiliary port.
 * Assumes the receive path hands over one character per pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module apoe_term (
  input wire logic pclk,
  output logic aux_rx_valid,
  output logic [7:0] aux_rx_char
);
  // ----------------------------------------------------------------
  // Character sender.
  // ----------------------------------------------------------------
  initial begin
    aux_rx_valid = 1'b0;
    aux_rx_char = 8'h00;
  end
  // The line shows the inverse afterwards, so stale data is not reused.
  task send(input logic [7:0] c);
    @(posedge pclk);
    aux_rx_valid <= 1'b1;
    aux_rx_char <= c;
    @(posedge pclk);
    aux_rx_valid <= 1'b0;
    aux_rx_char <= ~c;
  endtask
endmodule
`default_nettype wire

// ===== sim/aux_port_operator_entry_tb.sv
/*
 * Self-checking bench for the operator entry block.
 * Assumes the terminal model and the checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "apoe_defs.vh"
module aux_port_operator_entry_tb;
  // ----------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic program_running = 1'b0;
  logic thread0_running = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, com_divert, entry_active, aux_rx_valid;
  wire [7:0] aux_rx_char;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int tests_run = 0;
  always #12.5 pclk = ~pclk;
  apoe_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_rx_valid(aux_rx_valid), .aux_rx_char(aux_rx_char),
    .program_running(program_running), .thread0_running(thread0_running),
    .com_divert(com_divert), .entry_active(entry_active));
  apoe_term u_term (.pclk(pclk), .aux_rx_valid(aux_rx_valid),
    .aux_rx_char(aux_rx_char));
  // ----------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; the wait for pready is bounded.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      u_term.send(s[i]);
    end
  endtask
  // Watches four cycles for the divert, which must follow promptly.
  task div(input logic e);
    logic s;
    s = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      if (com_divert === 1'b1) s = 1'b1;
    end
    chk("divert", {31'h0, e}, {31'h0, s});
  endtask
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status off", `APOE_OFS_STAT, `APOE_ST_OFF);
    rdchk("selector", `APOE_OFS_CISEL, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("unmapped", 32'h0, rd);
    program_running <= 1'b1;
    thread0_running <= 1'b1;
    apb(1'b1, `APOE_OFS_CFG, 32'h1);
    rdchk("status idle", `APOE_OFS_STAT, 32'h0);
    chk("entry on", 32'h1, {31'h0, entry_active});
    send_str("-12");
    rdchk("status chars", `APOE_OFS_STAT, 32'h1);
    rdchk("last char", `APOE_OFS_LAST, 32'h32);
    send_str("\r");
    rdchk("status num", `APOE_OFS_STAT, 32'h3);
    rdchk("num frac", `APOE_OFS_NUMFRC, 32'h0);
    rdchk("num int", `APOE_OFS_NUMINT, 32'hfffffff4);
    rdchk("status clr", `APOE_OFS_STAT, 32'h0);
    send_str("+7\r");
    rdchk("plus num", `APOE_OFS_NUMINT, 32'h7);
    send_str("ABCDEFG\r");
    rdchk("status str", `APOE_OFS_STAT, 32'h2);
    rdchk("str lo", `APOE_OFS_STRLO, 32'h4546);
    rdchk("str hi", `APOE_OFS_STRHI, 32'h41424344);
    rdchk("status clr2", `APOE_OFS_STAT, 32'h0);
    apb(1'b1, `APOE_OFS_CFG, 32'h21);
    send_str("XYZ\r");
    rdchk("str hi len", `APOE_OFS_STRHI, 32'h58590000);
    rdchk("str lo len", `APOE_OFS_STRLO, 32'h0);
    apb(1'b1, `APOE_OFS_CISEL, 32'h0);
    send_str("\r");
    div(1'b0);
    apb(1'b1, `APOE_OFS_CISEL, 32'h1);
    send_str("A");
    div(1'b0);
    send_str("\r");
    div(1'b1);
    rdchk("handler", `APOE_OFS_HDL, 32'h2);
    apb(1'b1, `APOE_OFS_HDL, 32'h1);
    send_str("\r");
    div(1'b1);
    apb(1'b1, `APOE_OFS_HDL, 32'h0);
    send_str("\r");
    div(1'b0);
    apb(1'b1, `APOE_OFS_CISEL, 32'h2);
    send_str("Q");
    div(1'b1);
    apb(1'b1, `APOE_OFS_HDL, 32'h0);
    thread0_running <= 1'b0;
    apb(1'b1, `APOE_OFS_CISEL, 32'h2);
    send_str("Q");
    div(1'b0);
    send_str("12");
    apb(1'b1, `APOE_OFS_CISEL, `APOE_CI_FLUSH);
    send_str("\r");
    rdchk("flushed", `APOE_OFS_STRHI, 32'h0);
    program_running <= 1'b0;
    send_str("5");
    rdchk("last idle", `APOE_OFS_LAST, 32'h35);
    chk("entry idle", 32'h0, {31'h0, entry_active});
    program_running <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `APOE_OFS_CFG, 32'h1);
      u_term.send(k == 0 ? `APOE_CH_ESC : `APOE_CH_BSLASH);
      rdchk("status exit", `APOE_OFS_STAT, `APOE_ST_OFF);
      chk("entry exit", 32'h0, {31'h0, entry_active});
    end
    report_and_stop();
  end
endmodule
bind apoe_top apoe_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .aux_rx_valid(aux_rx_valid), .aux_rx_char(aux_rx_char),
  .program_running(program_running), .thread0_running(thread0_running),
  .com_divert(com_divert), .entry_active(entry_active));
`default_nettype wire
